// *** include/dual_half_timer_regs.vh ***
`ifndef DUAL_HALF_TIMER_REGS_VH
`define DUAL_HALF_TIMER_REGS_VH

// ****************************************
// operating modes
// ****************************************
`define MODE_ONE_SHOT 3'h0
`define MODE_PERIODIC 3'h1
`define MODE_RTC 3'h2
`define MODE_EDGE_COUNT 3'h3
`define MODE_EDGE_TIME 3'h4
`define MODE_PWM 3'h5

// ****************************************
// timeout actions on the capture/compare pin and the timeout irq
// ****************************************
`define ACT_NONE 4'h0
`define ACT_TIMEOUT_IRQ_SUPPRESS 4'h1
`define ACT_PIN_FLIP_ON_TIMEOUT 4'h2
`define ACT_PIN_HIGH_ON_TIMEOUT 4'h3
`define ACT_PIN_LOW_ON_TIMEOUT 4'h4
`define ACT_PRESET_HIGH_THEN_FLIP 4'h5
`define ACT_PRESET_LOW_THEN_FLIP 4'h6
`define ACT_PRESET_HIGH_THEN_LOW 4'h7
`define ACT_PRESET_LOW_THEN_HIGH 4'h8

// ****************************************
// capture edge selection
// ****************************************
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_EITHER 2'h2

// ****************************************
// dma trigger bit positions
// ****************************************
`define DMA_A_TIMEOUT 0
`define DMA_A_CAP_MATCH 1
`define DMA_A_CAP_EVENT 2
`define DMA_A_RTC_MATCH 3
`define DMA_A_MODE_MATCH 4
`define DMA_B_TIMEOUT 5
`define DMA_B_CAP_MATCH 6
`define DMA_B_CAP_EVENT 7
`define DMA_B_MODE_MATCH 8
`define DMA_BITS 9

// ****************************************
// reset values
// ****************************************
`define RST_MODE 3'h0
`define RST_ACT 4'h0
`define RST_DMA_MASK 9'h000

`endif

// *** design/half_counter.v ***
`timescale 1ns/100ps
`include "dual_half_timer_regs.vh"

module half_counter #(
	parameter CW = 32
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_ce,
	input wire i_start,
	input wire i_run,
	input wire i_tick,
	input wire i_edge,
	input wire [2:0] i_mode,
	input wire i_up,
	input wire [CW-1:0] i_load,
	input wire [CW-1:0] i_match,
	output reg [CW-1:0] o_count,
	output reg [CW-1:0] o_capture,
	output reg o_timeout,
	output reg o_mode_match,
	output reg o_cap_match,
	output reg o_cap_event,
	output reg o_done,
	output reg o_pwm_level
);

	wire [CW-1:0] one = {{(CW-1){1'b0}}, 1'b1};
	wire [CW-1:0] zero = {CW{1'b0}};
	wire step = i_run & i_tick;
	wire [CW-1:0] nxt = i_up ? o_count + one : o_count - one;
	wire at_end = i_up ? (o_count == i_load) : (o_count == zero);
	wire [CW-1:0] base = i_up ? zero : i_load;

	always @(posedge i_clk) begin
		if (i_rst) begin
			o_count <= zero;
			o_capture <= zero;
			o_timeout <= 1'b0;
			o_mode_match <= 1'b0;
			o_cap_match <= 1'b0;
			o_cap_event <= 1'b0;
			o_done <= 1'b0;
			o_pwm_level <= 1'b0;
		end else if (i_ce) begin
			o_timeout <= 1'b0;
			o_mode_match <= 1'b0;
			o_cap_match <= 1'b0;
			o_cap_event <= 1'b0;
			o_done <= 1'b0;
			o_pwm_level <= (i_mode == `MODE_PWM) & i_run & (o_count > i_match);
			if (i_start) begin
				o_count <= (i_mode == `MODE_RTC) ? zero : base;
			end else begin
				case (i_mode)
				`MODE_ONE_SHOT, `MODE_PERIODIC: begin
					if (step) begin
						if (at_end) begin
							o_timeout <= 1'b1;
							o_count <= base;
							o_done <= (i_mode == `MODE_ONE_SHOT);
						end else begin
							o_count <= nxt;
							o_mode_match <= (nxt == i_match);
						end
					end
				end
				`MODE_RTC: begin
					if (step) begin
						o_count <= o_count + one;
						o_mode_match <= ((o_count + one) == i_match);
					end
				end
				`MODE_EDGE_COUNT: begin
					if (i_run & i_edge) begin
						o_cap_event <= 1'b1;
						if (nxt == i_match) begin
							o_cap_match <= 1'b1;
							o_timeout <= 1'b1;
							o_count <= base;
						end else begin
							o_count <= nxt;
						end
					end
				end
				`MODE_EDGE_TIME: begin
					if (step) begin
						if (at_end) begin
							o_timeout <= 1'b1;
							o_count <= base;
						end else begin
							o_count <= nxt;
						end
					end
					if (i_run & i_edge) begin
						o_capture <= o_count;
						o_cap_event <= 1'b1;
					end
				end
				`MODE_PWM: begin
					if (step) begin
						if (o_count == zero) begin
							o_timeout <= 1'b1;
							o_count <= i_load;
						end else begin
							o_count <= o_count - one;
						end
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

endmodule // half_counter

// *** design/dual_half_timer.v ***
`timescale 1ns/100ps
`include "dual_half_timer_regs.vh"

module dual_half_timer #(
	parameter HW = 16,
	parameter HAS_UP = 1
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_ce,
	input wire i_cfg_apply,
	input wire i_cfg_split,
	input wire [2:0] i_cfg_full_mode,
	input wire [2:0] i_cfg_mode_a,
	input wire [2:0] i_cfg_mode_b,
	input wire i_cfg_up_a,
	input wire i_cfg_up_b,
	input wire [3:0] i_cfg_act_a,
	input wire [3:0] i_cfg_act_b,
	input wire i_enable_cmd,
	input wire i_disable_cmd,
	input wire [1:0] i_half_sel,
	input wire [1:0] i_edge_sel_a,
	input wire [1:0] i_edge_sel_b,
	input wire [1:0] i_output_polarity_low,
	input wire [1:0] i_debug_freeze,
	input wire i_debug_halt,
	input wire [1:0] i_adc_trig_en,
	input wire [1:0] i_chain_start_wait,
	input wire i_chain_trigger,
	input wire i_internal_osc_clock_sel,
	input wire i_osc_clk,
	input wire i_dma_mask_wr,
	input wire [`DMA_BITS-1:0] i_dma_mask,
	input wire [2*HW-1:0] i_load_a,
	input wire [HW-1:0] i_load_b,
	input wire [2*HW-1:0] i_match_a,
	input wire [HW-1:0] i_match_b,
	input wire [1:0] i_ccp_in,
	output reg [1:0] o_ccp_out,
	output reg [1:0] o_ccp_oe,
	output reg [1:0] o_timeout_irq,
	output reg [1:0] o_adc_trig,
	output reg [`DMA_BITS-1:0] o_dma_req,
	output reg [`DMA_BITS-1:0] o_dma_mask,
	output reg o_chain_timeout,
	output wire [1:0] o_active,
	output wire [2*HW-1:0] o_count_a,
	output wire [HW-1:0] o_count_b,
	output wire [2*HW-1:0] o_capture_a,
	output wire [HW-1:0] o_capture_b
);

	localparam ST_OFF = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_RUN = 3'b100;

	// ****************************************
	// functions
	// ****************************************
	function [2:0] next_state;
		input [2:0] st;
		input en;
		input dis;
		input wt;
		input trig;
		input done;
		begin
			next_state = st;
			case (st)
			ST_OFF: begin
				if (en & ~dis) next_state = wt ? ST_WAIT : ST_RUN;
			end
			ST_WAIT: begin
				if (dis) next_state = ST_OFF;
				else if (trig) next_state = ST_RUN;
			end
			ST_RUN: begin
				if (dis | done) next_state = ST_OFF;
			end
			default: next_state = ST_OFF;
			endcase
		end
	endfunction

	function pin_preset;
		input [3:0] act;
		input cur;
		begin
			case (act)
			`ACT_PRESET_HIGH_THEN_FLIP, `ACT_PRESET_HIGH_THEN_LOW: pin_preset = 1'b1;
			`ACT_PRESET_LOW_THEN_FLIP, `ACT_PRESET_LOW_THEN_HIGH: pin_preset = 1'b0;
			default: pin_preset = cur;
			endcase
		end
	endfunction

	function pin_on_timeout;
		input [3:0] act;
		input cur;
		begin
			case (act)
			`ACT_PIN_FLIP_ON_TIMEOUT, `ACT_PRESET_HIGH_THEN_FLIP,
			`ACT_PRESET_LOW_THEN_FLIP: pin_on_timeout = ~cur;
			`ACT_PIN_HIGH_ON_TIMEOUT, `ACT_PRESET_LOW_THEN_HIGH: pin_on_timeout = 1'b1;
			`ACT_PIN_LOW_ON_TIMEOUT, `ACT_PRESET_HIGH_THEN_LOW: pin_on_timeout = 1'b0;
			default: pin_on_timeout = cur;
			endcase
		end
	endfunction

	function edge_hit;
		input [1:0] sel;
		input cur;
		input prev;
		begin
			case (sel)
			`EDGE_RISE: edge_hit = cur & ~prev;
			`EDGE_FALL: edge_hit = ~cur & prev;
			`EDGE_EITHER: edge_hit = cur ^ prev;
			default: edge_hit = 1'b0;
			endcase
		end
	endfunction

	function is_capture;
		input [2:0] m;
		begin
			is_capture = (m == `MODE_EDGE_COUNT) | (m == `MODE_EDGE_TIME);
		end
	endfunction

	function up_allowed;
		input [2:0] m;
		begin
			up_allowed = (HAS_UP != 0) & ((m == `MODE_ONE_SHOT) | (m == `MODE_PERIODIC) |
				is_capture(m));
		end
	endfunction

	// ****************************************
	// configuration, latched atomically
	// ****************************************
	reg split_q;
	reg [2:0] mode_a_q;
	reg [2:0] mode_b_q;
	reg up_a_q;
	reg up_b_q;
	reg [3:0] act_a_q;
	reg [3:0] act_b_q;
	wire full_ok = (i_cfg_full_mode == `MODE_ONE_SHOT) | (i_cfg_full_mode == `MODE_PERIODIC) |
		(i_cfg_full_mode == `MODE_RTC);

	always @(posedge i_clk) begin
		if (i_rst) begin
			split_q <= 1'b0;
			mode_a_q <= `RST_MODE;
			mode_b_q <= `RST_MODE;
			up_a_q <= 1'b0;
			up_b_q <= 1'b0;
			act_a_q <= `RST_ACT;
			act_b_q <= `RST_ACT;
		end else if (i_ce & i_cfg_apply) begin
			split_q <= i_cfg_split;
			if (i_cfg_split) begin
				mode_a_q <= (i_cfg_mode_a == `MODE_RTC) ? `MODE_ONE_SHOT : i_cfg_mode_a;
				mode_b_q <= (i_cfg_mode_b == `MODE_RTC) ? `MODE_ONE_SHOT : i_cfg_mode_b;
				up_a_q <= i_cfg_up_a & up_allowed(i_cfg_mode_a);
				up_b_q <= i_cfg_up_b & up_allowed(i_cfg_mode_b);
			end else begin
				// illegal full-width modes fall back to one-shot
				mode_a_q <= full_ok ? i_cfg_full_mode : `MODE_ONE_SHOT;
				mode_b_q <= `RST_MODE;
				up_a_q <= i_cfg_up_a & full_ok & up_allowed(i_cfg_full_mode);
				up_b_q <= 1'b0;
			end
			act_a_q <= i_cfg_act_a;
			act_b_q <= i_cfg_act_b;
		end
	end

	// ****************************************
	// synchronisers for pins and oscillator
	// ****************************************
	reg [1:0] cap_s1_q;
	reg [1:0] cap_s2_q;
	reg [1:0] cap_s3_q;
	reg osc_s1_q;
	reg osc_s2_q;
	reg osc_s3_q;

	always @(posedge i_clk) begin
		if (i_rst) begin
			cap_s1_q <= 2'h0;
			cap_s2_q <= 2'h0;
			cap_s3_q <= 2'h0;
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
		end else if (i_ce) begin
			cap_s1_q <= i_ccp_in;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
			osc_s1_q <= i_osc_clk;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end

	// oscillator must run below half the system clock to be seen
	wire tick = i_internal_osc_clock_sel ? (osc_s2_q & ~osc_s3_q) : 1'b1;
	wire edge_a = edge_hit(i_edge_sel_a, cap_s2_q[0], cap_s3_q[0]);
	wire edge_b = edge_hit(i_edge_sel_b, cap_s2_q[1], cap_s3_q[1]);

	// ****************************************
	// enable state per half
	// ****************************************
	reg [2:0] st_a_q;
	reg [2:0] st_b_q;
	reg [2:0] st_a_d;
	reg [2:0] st_b_d;
	wire to_a;
	wire to_b;
	wire done_a;
	wire done_b;
	wire en_a = i_enable_cmd & (i_half_sel[0] | (~split_q & i_half_sel[1]));
	wire en_b = i_enable_cmd & i_half_sel[1] & split_q;
	wire dis_a = i_disable_cmd & (i_half_sel[0] | (~split_q & i_half_sel[1]));
	wire dis_b = i_disable_cmd & i_half_sel[1];

	always @* begin
		st_a_d = next_state(st_a_q, en_a, dis_a, i_chain_start_wait[0], i_chain_trigger, done_a);
		st_b_d = next_state(st_b_q, en_b, dis_b, i_chain_start_wait[1], to_a, done_b);
		if (i_cfg_apply) begin
			st_a_d = ST_OFF;
			st_b_d = ST_OFF;
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			st_a_q <= ST_OFF;
			st_b_q <= ST_OFF;
		end else if (i_ce) begin
			st_a_q <= st_a_d;
			st_b_q <= st_b_d;
		end
	end

	assign o_active = {st_b_q == ST_RUN, st_a_q == ST_RUN};
	wire start_a = (st_a_d == ST_RUN) & (st_a_q != ST_RUN);
	wire start_b = (st_b_d == ST_RUN) & (st_b_q != ST_RUN);
	wire run_a = (st_a_q == ST_RUN) & ~(i_debug_freeze[0] & i_debug_halt);
	wire run_b = (st_b_q == ST_RUN) & ~(i_debug_freeze[1] & i_debug_halt);

	// ****************************************
	// counters
	// ****************************************
	// split half a only sees the low half of its load and match
	wire [2*HW-1:0] load_a = split_q ? {{HW{1'b0}}, i_load_a[HW-1:0]} : i_load_a;
	wire [2*HW-1:0] match_a = split_q ? {{HW{1'b0}}, i_match_a[HW-1:0]} : i_match_a;
	wire mm_a;
	wire cm_a;
	wire ce_a;
	wire pwm_a;
	wire mm_b;
	wire cm_b;
	wire ce_b;
	wire pwm_b;

	half_counter #(.CW(2 * HW)) u_half_a (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_start(start_a),
		.i_run(run_a),
		.i_tick(tick),
		.i_edge(edge_a),
		.i_mode(mode_a_q),
		.i_up(up_a_q),
		.i_load(load_a),
		.i_match(match_a),
		.o_count(o_count_a),
		.o_capture(o_capture_a),
		.o_timeout(to_a),
		.o_mode_match(mm_a),
		.o_cap_match(cm_a),
		.o_cap_event(ce_a),
		.o_done(done_a),
		.o_pwm_level(pwm_a)
	);

	half_counter #(.CW(HW)) u_half_b (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_start(start_b),
		.i_run(run_b),
		.i_tick(tick),
		.i_edge(edge_b),
		.i_mode(mode_b_q),
		.i_up(up_b_q),
		.i_load(i_load_b),
		.i_match(i_match_b),
		.o_count(o_count_b),
		.o_capture(o_capture_b),
		.o_timeout(to_b),
		.o_mode_match(mm_b),
		.o_cap_match(cm_b),
		.o_cap_event(ce_b),
		.o_done(done_b),
		.o_pwm_level(pwm_b)
	);

	// ****************************************
	// pin actions and outputs
	// ****************************************
	reg [1:0] pin_q;
	wire rtc_a = mode_a_q == `MODE_RTC;
	wire [`DMA_BITS-1:0] dma_ev;
	assign dma_ev[`DMA_A_TIMEOUT] = to_a;
	assign dma_ev[`DMA_A_CAP_MATCH] = cm_a;
	assign dma_ev[`DMA_A_CAP_EVENT] = ce_a;
	assign dma_ev[`DMA_A_RTC_MATCH] = mm_a & rtc_a;
	assign dma_ev[`DMA_A_MODE_MATCH] = mm_a & ~rtc_a;
	assign dma_ev[`DMA_B_TIMEOUT] = to_b;
	assign dma_ev[`DMA_B_CAP_MATCH] = cm_b;
	assign dma_ev[`DMA_B_CAP_EVENT] = ce_b;
	assign dma_ev[`DMA_B_MODE_MATCH] = mm_b;

	always @(posedge i_clk) begin
		if (i_rst) begin
			pin_q <= 2'h0;
			o_ccp_out <= 2'h0;
			o_ccp_oe <= 2'h0;
			o_timeout_irq <= 2'h0;
			o_adc_trig <= 2'h0;
			o_dma_req <= {`DMA_BITS{1'b0}};
			o_dma_mask <= `RST_DMA_MASK;
			o_chain_timeout <= 1'b0;
		end else if (i_ce) begin
			// presets use the incoming actions so the pin moves with the apply
			if (i_cfg_apply) begin
				pin_q[0] <= pin_preset(i_cfg_act_a, pin_q[0]);
				pin_q[1] <= pin_preset(i_cfg_act_b, pin_q[1]);
			end else begin
				if (to_a) pin_q[0] <= pin_on_timeout(act_a_q, pin_q[0]);
				if (to_b) pin_q[1] <= pin_on_timeout(act_b_q, pin_q[1]);
			end
			o_ccp_out[0] <= (mode_a_q == `MODE_PWM) ? pwm_a ^ i_output_polarity_low[0] : pin_q[0];
			o_ccp_out[1] <= (mode_b_q == `MODE_PWM) ? pwm_b ^ i_output_polarity_low[1] : pin_q[1];
			o_ccp_oe[0] <= ~is_capture(mode_a_q);
			o_ccp_oe[1] <= split_q & ~is_capture(mode_b_q);
			o_timeout_irq[0] <= to_a & (act_a_q != `ACT_TIMEOUT_IRQ_SUPPRESS);
			o_timeout_irq[1] <= to_b & (act_b_q != `ACT_TIMEOUT_IRQ_SUPPRESS);
			o_adc_trig <= {to_b, to_a} & i_adc_trig_en;
			o_dma_req <= dma_ev & o_dma_mask;
			if (i_dma_mask_wr) o_dma_mask <= i_dma_mask;
			o_chain_timeout <= split_q ? to_b : to_a;
		end
	end

endmodule // dual_half_timer

// *** sim/dual_half_timer_properties.sv ***
`timescale 1ns/100ps
`include "dual_half_timer_regs.vh"
module dual_half_timer_properties #(
	parameter HW = 16
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_ce,
	input wire i_cfg_apply,
	input wire i_enable_cmd,
	input wire i_disable_cmd,
	input wire [1:0] i_half_sel,
	input wire [1:0] i_debug_freeze,
	input wire i_debug_halt,
	input wire [1:0] i_adc_trig_en,
	input wire [1:0] i_chain_start_wait,
	input wire i_dma_mask_wr,
	input wire [`DMA_BITS-1:0] i_dma_mask,
	input wire [1:0] o_adc_trig,
	input wire [`DMA_BITS-1:0] o_dma_req,
	input wire [`DMA_BITS-1:0] o_dma_mask,
	input wire [1:0] o_active,
	input wire [2*HW-1:0] o_count_a
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// ****
	// commands
	// ****
	sequence s_en_a;
		i_ce && i_enable_cmd && i_half_sel[0] && !i_disable_cmd && !i_cfg_apply
			&& !i_chain_start_wait[0];
	endsequence
	sequence s_halt;
		(i_ce && i_debug_freeze[0] && i_debug_halt && !i_enable_cmd && !i_cfg_apply)[*3];
	endsequence
	property p_apply_stops;
		i_ce && i_cfg_apply |=> o_active == 2'h0;
	endproperty
	a_apply_stops: assert property (p_apply_stops) else $error("active after apply");
	property p_dis_both;
		i_ce && i_disable_cmd && i_half_sel == 2'h3 |=> o_active == 2'h0;
	endproperty
	a_dis_both: assert property (p_dis_both) else $error("active after disable");
	property p_dis_b;
		i_ce && i_disable_cmd && i_half_sel[1] |=> !o_active[1];
	endproperty
	a_dis_b: assert property (p_dis_b) else $error("b active after disable");
	property p_en_a;
		s_en_a |=> o_active[0];
	endproperty
	a_en_a: assert property (p_en_a) else $error("a idle after enable");
	// ****
	// events
	// ****
	property p_adc_gate;
		i_adc_trig_en == 2'h0 && $past(i_adc_trig_en) == 2'h0
			&& $past(i_adc_trig_en, 2) == 2'h0 |-> o_adc_trig == 2'h0;
	endproperty
	a_adc_gate: assert property (p_adc_gate) else $error("adc pulse while off");
	// mask compared over two cycles, so a write in flight is not misread
	property p_dma_gate;
		$stable(o_dma_mask) && o_dma_mask == $past(o_dma_mask, 2)
			|-> (o_dma_req & ~o_dma_mask) == 9'h000;
	endproperty
	a_dma_gate: assert property (p_dma_gate) else $error("dma req not enabled");
	property p_mask_rb;
		i_ce && i_dma_mask_wr |=> o_dma_mask == $past(i_dma_mask);
	endproperty
	a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
	property p_freeze;
		s_halt |-> $stable(o_count_a);
	endproperty
	a_freeze: assert property (p_freeze) else $error("count moved in halt");
endmodule // dual_half_timer_properties

bind dual_half_timer dual_half_timer_properties #(.HW(HW)) u_props (.i_clk(i_clk),
	.i_rst(i_rst), .i_ce(i_ce), .i_cfg_apply(i_cfg_apply), .i_enable_cmd(i_enable_cmd),
	.i_disable_cmd(i_disable_cmd), .i_half_sel(i_half_sel), .i_debug_freeze(i_debug_freeze),
	.i_debug_halt(i_debug_halt), .i_adc_trig_en(i_adc_trig_en),
	.i_chain_start_wait(i_chain_start_wait), .i_dma_mask_wr(i_dma_mask_wr),
	.i_dma_mask(i_dma_mask), .o_adc_trig(o_adc_trig), .o_dma_req(o_dma_req),
	.o_dma_mask(o_dma_mask), .o_active(o_active), .o_count_a(o_count_a));

// *** sim/ccp_pin_model.sv ***
`timescale 1ns/100ps
module ccp_pin_model (
	input wire i_clk,
	input wire i_go,
	input wire [3:0] i_edges,
	output reg o_pin,
	output reg o_chain
);
	reg [3:0] left_q = 4'h0;
	reg [2:0] div_q = 3'h0;
	initial o_pin = 1'b0;
	initial o_chain = 1'b0;
	// slow edges, well inside what the pin synchroniser can follow
	always @(posedge i_clk) begin
		o_chain <= 1'b0;
		div_q <= div_q + 3'h1;
		if (i_go) begin
			left_q <= i_edges;
		end else if (left_q != 4'h0 && div_q == 3'h7) begin
			o_pin <= ~o_pin;
			left_q <= left_q - 4'h1;
			o_chain <= (left_q == 4'h1);
		end
	end
endmodule // ccp_pin_model

// *** sim/dual_half_timer_test.sv ***
`timescale 1ns/100ps
`include "dual_half_timer_regs.vh"
module dual_half_timer_test;
	logic i_clk = 0, i_rst = 1, apply = 0, split = 1, en = 0, dis = 0, halt = 0, wr = 0;
	logic go = 0, pa = 0, pb = 0, seen, ce = 1, osel = 0;
	logic [1:0] ocnt = 0;
	wire [1:0] oe;
	logic [2:0] fm = 0, ma = 0, mb = 0;
	logic [3:0] aa = 0, ab = 0, ne = 4;
	logic [1:0] sel = 1, esa = 0, pol = 0, frz = 0, adc = 0, wt = 0, up = 0;
	logic [8:0] mask = 0;
	logic [15:0] la = 3, mta = 0;
	logic [7:0] lb = 8'h40;
	wire pin, chain;
	wire [1:0] ccp, act, irq, atr;
	wire [8:0] dreq, dmask;
	wire [15:0] cnt;
	int err_count = 0, n_tests = 0, k, c, h;
	dual_half_timer #(.HW(8), .HAS_UP(1)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
		.i_cfg_apply(apply), .i_cfg_split(split), .i_cfg_full_mode(fm), .i_cfg_mode_a(ma),
		.i_cfg_mode_b(mb), .i_cfg_up_a(up[0]), .i_cfg_up_b(up[1]), .i_cfg_act_a(aa),
		.i_cfg_act_b(ab), .i_enable_cmd(en), .i_disable_cmd(dis), .i_half_sel(sel),
		.i_edge_sel_a(esa), .i_edge_sel_b(2'h0), .i_output_polarity_low(pol),
		.i_debug_freeze(frz), .i_debug_halt(halt), .i_adc_trig_en(adc),
		.i_chain_start_wait(wt), .i_chain_trigger(chain), .i_internal_osc_clock_sel(osel),
		.i_osc_clk(ocnt[1]), .i_dma_mask_wr(wr), .i_dma_mask(mask), .i_load_a(la), .i_load_b(lb),
		.i_match_a(mta), .i_match_b(8'hff), .i_ccp_in({1'b0, pin}), .o_ccp_out(ccp),
		.o_ccp_oe(oe), .o_timeout_irq(irq), .o_adc_trig(atr), .o_dma_req(dreq),
		.o_dma_mask(dmask), .o_chain_timeout(), .o_active(act), .o_count_a(cnt),
		.o_count_b(), .o_capture_a(), .o_capture_b());
	ccp_pin_model u_pin (.i_clk(i_clk), .i_go(go), .i_edges(ne), .o_pin(pin), .o_chain(chain));
	initial forever #5 i_clk = ~i_clk;
	// slow oscillator, a rising edge every four system cycles
	always @(negedge i_clk) ocnt <= ocnt + 2'h1;
	// ****
	// tasks
	// ****
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic pulse(ref logic s);
		@(negedge i_clk);
		s = 1;
		@(negedge i_clk);
		s = 0;
	endtask
	task automatic cfg(input logic [2:0] a, input logic [2:0] b, input logic [3:0] x);
		ma = a;
		mb = b;
		aa = x;
		ab = x;
		pulse(apply);
	endtask
	// waits for an a-side timeout pulse; a run-out ends the test
	task automatic wirq(input int lim, output int n);
		n = 0;
		while (irq[0] !== 1'b1 && n < lim) begin
			@(negedge i_clk);
			n++;
		end
		if (n == lim) begin
			err_count++;
			finish_test();
		end
	endtask
	task automatic finish_test();
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****
	// sequence
	// ****
	initial begin
		tick(10);
		i_rst = 0;
		chk("reset act", 0, act);
		mask = 9'h1ff;
		pulse(wr);
		chk("mask", 9'h1ff, dmask);
		for (k = 0; k < 9; k++) begin
			cfg(`MODE_ONE_SHOT, `MODE_ONE_SHOT, k[3:0]);
			if (k >= 5) pa = (k == 5 || k == 7);
			if (k >= 5) pb = pa;
			tick(1);
			chk("preset", {pb, pa}, ccp);
			pulse(en);
			seen = 0;
			repeat (12) begin
				@(negedge i_clk);
				seen |= irq[0];
			end
			if (k == 2 || k == 5 || k == 6) pa = ~pa;
			if (k == 3 || k == 8) pa = 1;
			if (k == 4 || k == 7) pa = 0;
			chk("pin at timeout", {pb, pa}, ccp);
			chk("irq", k != 1, seen);
			chk("one-shot stop", 0, act[0]);
		end
		la = 5;
		adc = 1;
		mask = 9'h001;
		pulse(wr);
		cfg(`MODE_PERIODIC, `MODE_PERIODIC, `ACT_PIN_FLIP_ON_TIMEOUT);
		pulse(en);
		chk("enable a", 1, act);
		wirq(50, c);
		chk("adc", 1, atr[0]);
		chk("dma", 1, dreq[0]);
		tick(1);
		wirq(50, c);
		chk("period", 5, c);
		chk("flip", !pa, ccp[0]);
		adc = 0;
		mask = 0;
		pulse(wr);
		tick(1);
		wirq(50, c);
		chk("adc off", 0, atr[0]);
		chk("dma off", 0, dreq);
		frz = 1;
		halt = 1;
		tick(2);
		h = cnt;
		tick(8);
		chk("frozen", h, cnt);
		frz = 0;
		tick(2);
		chk("no freeze", 1, cnt != h);
		halt = 0;
		cfg(`MODE_PERIODIC, `MODE_PERIODIC, `ACT_TIMEOUT_IRQ_SUPPRESS);
		tick(20);
		chk("stopped", 0, act);
		pulse(en);
		c = 0;
		repeat (30) begin
			@(negedge i_clk);
			c += irq[0];
		end
		chk("suppressed", 0, c);
		up = 1;
		la = 0;
		mta = 16'h00ff;
		for (k = 0; k < 3; k++) begin
			esa = k[1:0];
			cfg(`MODE_EDGE_COUNT, `MODE_EDGE_TIME, `ACT_NONE);
			pulse(en);
			chk("oe capture", 0, oe[0]);
			h = cnt;
			pulse(go);
			tick(50);
			chk("edges", k == 2 ? 4 : 2, cnt - h);
		end
		la = 9;
		mta = 3;
		for (k = 0; k < 2; k++) begin
			pol = k[1:0];
			cfg(`MODE_PWM, `MODE_PWM, `ACT_NONE);
			pulse(en);
			tick(5);
			chk("oe pwm", 1, oe[0]);
			c = 0;
			repeat (30) begin
				@(negedge i_clk);
				c += ccp[0];
			end
			if (k == 0) h = c;
		end
		chk("pwm shape", 1, h > 0 && h < 30);
		chk("pwm inverted", 30 - h, c);
		la = 3;
		wt = 2'b10; // chain head left alone
		cfg(`MODE_ONE_SHOT, `MODE_ONE_SHOT, `ACT_NONE);
		sel = 2'b10;
		pulse(en);
		tick(20);
		chk("b waits", 0, act[1]);
		sel = 2'b01;
		pulse(en);
		tick(8);
		chk("b started", 1, act[1]);
		sel = 2'b10;
		pulse(dis);
		chk("b stopped", 0, act[1]);
		wt = 0;
		split = 0;
		fm = `MODE_PERIODIC;
		la = 16'h0100;
		cfg(`MODE_ONE_SHOT, `MODE_ONE_SHOT, `ACT_NONE);
		pulse(en);
		chk("full enable", 1, act);
		wirq(300, c);
		tick(1);
		wirq(300, c);
		chk("full period", 256, c);
		chk("oe b off", 0, oe[1]);
		la = 3;
		osel = 1;
		cfg(`MODE_ONE_SHOT, `MODE_ONE_SHOT, `ACT_NONE);
		pulse(en);
		wirq(100, c);
		tick(1);
		wirq(100, c);
		chk("osc period", 15, c);
		ce = 0;
		h = cnt;
		tick(8);
		chk("ce freeze", h, cnt);
		chk("ce hold", 1, act);
		ce = 1;
		sel = 2'b11;
		pulse(dis);
		chk("disabled", 0, act);
		finish_test();
	end
endmodule // dual_half_timer_test
